// *** rtl/rcsc_pkg.sv ***
// Package for the reference clock start-up control block
`default_nettype none
package rcsc_pkg;

  // Start-up hold-off, counted in slow ticks (low-power oscillator or divided external clock)
  localparam logic [4:0]  RCSC_WAIT_DEFAULT  = 5'h05;
  localparam logic [4:0]  RCSC_WAIT_MAX      = 5'h1f;
  // External 32 kHz slow clock is divided by this before use
  localparam int          RCSC_EXT_DIV       = 32;
  localparam logic [4:0]  RCSC_EXT_DIV_LAST  = 5'h1f;
  // Reference frequency in kHz units, reset value 26 MHz
  localparam logic [15:0] RCSC_FREQ_DEFAULT  = 16'h6590;
  localparam logic [15:0] RCSC_FREQ_STEP_KHZ = 16'h00fa;
  localparam logic [15:0] RCSC_FREQ_MIN_CELL = 16'h1e00;
  localparam logic [15:0] RCSC_FREQ_MAX_CELL = 16'h9600;
  // Crystal trim: 6-bit code, capacitor step in fF, series load step in fF
  localparam int          RCSC_TRIM_W        = 6;
  localparam logic [5:0]  RCSC_TRIM_DEFAULT  = 6'h1f;
  localparam logic [15:0] RCSC_TRIM_CAP_FF   = 16'h006e;
  localparam logic [15:0] RCSC_TRIM_LOAD_FF  = 16'h0037;

  // Start-up sequencer states, Gray coded
  typedef enum logic [1:0] {
    RCSC_IDLE = 2'b00,
    RCSC_WAIT = 2'b01,
    RCSC_RUN  = 2'b11
  } rcsc_state_t;

  // Configuration carried into the block
  typedef struct packed {
    logic [4:0]  startup_wait_setting;
    logic [15:0] ref_freq_setting;
    logic [5:0]  crystal_trim_setting;
    logic        ext_slow_clk_sel;
  } rcsc_cfg_t;

  // Analog trim outputs
  typedef struct packed {
    logic [5:0]  trim_capacitor;
    logic [15:0] trim_cap_ff;
    logic [15:0] trim_load_ff;
  } rcsc_trim_t;

endpackage : rcsc_pkg
`default_nettype wire

// *** rtl/rcsc_slow_tick.sv ***
// Slow-clock tick generator with optional divide of the external clock
`timescale 1ns/1ps
`default_nettype none
module rcsc_slow_tick (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ext_sel,
  input  wire logic low_power_osc,
  input  wire logic ext_slow_clk,
  output var  logic tick
);
  import rcsc_pkg::*;

  typedef struct packed {
    logic       osc_q;
    logic       ext_q;
    logic [4:0] div;
    logic       tick;
  } rcsc_tick_st_t;

  rcsc_tick_st_t st;
  rcsc_tick_st_t next_st;

  // Rising edges of the chosen slow clock; external one counted down by 32
  always_comb begin
    next_st       = st;
    next_st.osc_q = low_power_osc;
    next_st.ext_q = ext_slow_clk;
    next_st.tick  = 1'b0;
    if (ext_sel) begin
      if (ext_slow_clk && !st.ext_q) begin
        next_st.div = st.div + 5'h01;
        if (st.div == RCSC_EXT_DIV_LAST) begin
          next_st.tick = 1'b1;
        end
      end
    end else begin
      next_st.div  = 5'h00;
      next_st.tick = low_power_osc && !st.osc_q;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // rcsc_slow_tick
`default_nettype wire

// *** rtl/rcsc_ctrl.sv ***
// Reference clock start-up control: firmware hold-off and clock settings
// How it works
// - Hold firmware after clock request, default five
// - Programmed wait 1..31 slow cycles replaces default
// - Wait setting zero means five cycles
// - External 32 kHz slow clock divided by 32
// - Reference frequency held in kHz, default 26000
// - Any nonzero 250 kHz multiple is a valid setting
// - Ten listed cellular frequencies from 7680 to 38400 kHz also accepted
// - Trim capacitor equals 110 fF times code
// - Each trim step adds 55 fF load

// Sequencer walk
//   IDLE: waits for a rising clock request. The wait setting is latched as
//         the target here, so a later load of the wait setting only affects the
//         next request, never the hold-off already under way.
//   WAIT: counts slow ticks from zero while busy is shown and firmware is
//         held. Dropping the request returns to IDLE and discards the count.
//   RUN:  firmware may run until the request drops. A request must fall
//         and rise again before another hold-off starts.
//
// Timing
//   The request is seen on the clock after it rises and busy follows on
//   that same edge. Each slow tick is one clock late (edge detect plus a
//   register), so the release lands one clock after the edge that carries
//   the last tick of the count.
//   The first tick after a request can come anywhere within one slow
//   period, so the real hold-off lies between N-1 and N slow periods plus
//   a few clocks. Pick the wait setting with that margin in mind.
//
// Slow clock choice
//   The source selector is taken from the stored settings, not straight
//   from the input word, so the tick source only changes on a load.
//   The external divider runs freely while it is selected; a request does
//   not re-phase it, which keeps the tick period steady.
//
// Settings
//   The frequency word is stored exactly as loaded, whatever its value;
//   the valid flag only reports whether it is a nonzero 250 kHz multiple
//   or one of the listed cellular codes.
//   The trim outputs follow the stored code one clock later, giving the
//   capacitor value per side and the effective load across the crystal.
//
// Reset
//   Reset is synchronous. It clears the sequencer to IDLE, restores the
//   default frequency word and the mid-scale trim code, and clears the
//   trim outputs until the first clock after release.
//   Every output comes from the state register, never from an input.
`timescale 1ns/1ps
`default_nettype none
module rcsc_ctrl (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_request,
  input  wire logic                 low_power_osc,
  input  wire logic                 ext_slow_clk,
  input  wire logic                 cfg_load,
  input  wire rcsc_pkg::rcsc_cfg_t  cfg_in,
  output var  logic                 firmware_run,
  output var  logic                 holdoff_busy,
  output var  logic                 freq_valid,
  output var  logic [15:0]          ref_freq_setting,
  output var  rcsc_pkg::rcsc_trim_t trim_out
);
  import rcsc_pkg::*;

  typedef struct packed {
    // Sequencer
    rcsc_state_t state;
    logic        req_q;
    logic [4:0]  count;
    logic [4:0]  target;
    // Stored settings
    logic [4:0]  wait_cfg;
    logic        ext_sel;
    logic [15:0] freq;
    logic        freq_ok;
    logic [5:0]  trim;
    // Registered outputs
    rcsc_trim_t  trim_o;
    logic        run;
    logic        busy;
  } rcsc_ctrl_st_t;

  rcsc_ctrl_st_t st;
  rcsc_ctrl_st_t next_st;
  logic          slow_tick;

  // Slow tick from internal oscillator or divided external clock
  rcsc_slow_tick u_tick (
    .core_clk      (core_clk),
    .srst          (srst),
    .ext_sel       (st.ext_sel),
    .low_power_osc (low_power_osc),
    .ext_slow_clk  (ext_slow_clk),
    .tick          (slow_tick)
  );

  // Listed cellular reference codes in kHz that are not 250 kHz multiples
  localparam int          RCSC_CELL_N = 10;
  localparam logic [15:0] RCSC_CELL_FREQ [RCSC_CELL_N] = '{
    16'h1e00, // 7.68 MHz
    16'h3840, // 14.40 MHz
    16'h3c00, // 15.36 MHz
    16'h3f48, // 16.20 MHz
    16'h41a0, // 16.80 MHz
    16'h4b00, // 19.20 MHz
    16'h4bf0, // 19.44 MHz
    16'h4ce0, // 19.68 MHz
    16'h4d58, // 19.80 MHz
    16'h9600  // 38.40 MHz
  };

  // True for a nonzero 250 kHz multiple
  function automatic logic freq_step_ok_f(input logic [15:0] f);
    return ((f % RCSC_FREQ_STEP_KHZ) == 16'h0000) && (f != 16'h0000);
  endfunction

  // True for one of the listed cellular codes
  function automatic logic freq_cell_ok_f(input logic [15:0] f);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < RCSC_CELL_N; i++) begin
      if (f == RCSC_CELL_FREQ[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Accept a frequency that is a nonzero 250 kHz multiple or a listed cellular value
  function automatic logic freq_ok_f(input logic [15:0] f);
    return freq_step_ok_f(f) || freq_cell_ok_f(f);
  endfunction

  // Configuration, hold-off sequencer and trim mapping
  always_comb begin
    next_st       = st;
    // Request history for the rising-edge test
    next_st.req_q = clk_request;
    // Settings load; the wait setting is only used at the next request
    if (cfg_load) begin
      next_st.wait_cfg = cfg_in.startup_wait_setting;
      next_st.ext_sel  = cfg_in.ext_slow_clk_sel;
      next_st.freq     = cfg_in.ref_freq_setting;
      next_st.freq_ok  = freq_ok_f(cfg_in.ref_freq_setting);
      next_st.trim     = cfg_in.crystal_trim_setting;
    end
    // Trim outputs follow the stored code one clock later
    next_st.trim_o.trim_capacitor = st.trim;
    next_st.trim_o.trim_cap_ff    = 16'(st.trim) * RCSC_TRIM_CAP_FF;
    next_st.trim_o.trim_load_ff   = 16'(st.trim) * RCSC_TRIM_LOAD_FF;
    // Hold-off sequencer
    unique case (st.state)
      RCSC_IDLE: begin
        // A fresh rise restarts the count and latches the target
        if (clk_request && !st.req_q) begin
          next_st.state  = RCSC_WAIT;
          next_st.count  = 5'h00;
          next_st.target = (st.wait_cfg == 5'h00) ? RCSC_WAIT_DEFAULT
                                                  : st.wait_cfg;
        end
      end
      RCSC_WAIT: begin
        // Dropping the request abandons the count
        if (!clk_request) begin
          next_st.state = RCSC_IDLE;
        end else if (slow_tick) begin
          next_st.count = st.count + 5'h01;
          // Release on the tick that completes the count
          if (st.count + 5'h01 == st.target) begin
            next_st.state = RCSC_RUN;
          end
        end
      end
      RCSC_RUN: begin
        // Firmware runs until the request is withdrawn
        if (!clk_request) begin
          next_st.state = RCSC_IDLE;
        end
      end
      // The unused code falls back to idle
      default: next_st.state = RCSC_IDLE;
    endcase
    // Flags come from the next state so both outputs stay registered
    next_st.run  = (next_st.state == RCSC_RUN);
    next_st.busy = (next_st.state == RCSC_WAIT);
  end

  // State register with reset values
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // Every field named so the values after reset are plain to see
      st.state    <= RCSC_IDLE;
      st.req_q    <= 1'b0;
      st.count    <= 5'h00;
      st.target   <= 5'h00;
      st.wait_cfg <= 5'h00;
      st.ext_sel  <= 1'b0;
      st.freq     <= RCSC_FREQ_DEFAULT;
      st.freq_ok  <= 1'b1;
      st.trim     <= RCSC_TRIM_DEFAULT;
      st.trim_o   <= '0;
      st.run      <= 1'b0;
      st.busy     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Sequencer flags
  assign firmware_run     = st.run;
  assign holdoff_busy     = st.busy;

  // Settings status and trim
  assign freq_valid       = st.freq_ok;
  assign ref_freq_setting = st.freq;
  assign trim_out         = st.trim_o;
endmodule // rcsc_ctrl
`default_nettype wire

// *** tb/rcsc_chk.sv ***
// Port checker for the start-up control block
`timescale 1ns/1ps
`default_nettype none
module rcsc_chk (
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire logic                 clk_request,
  input wire logic                 firmware_run,
  input wire logic                 holdoff_busy,
  input wire logic [15:0]          ref_freq_setting,
  input wire rcsc_pkg::rcsc_trim_t trim_out
);
  import rcsc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Hold-off sequencing
  a_busy_on_req: assert property ($rose(clk_request) && !holdoff_busy && !firmware_run
    |=> holdoff_busy) else $error("no busy");
  a_run_drops: assert property (!clk_request |=> !firmware_run) else $error("run kept");
  a_run_stands: assert property (firmware_run && clk_request |=> firmware_run)
    else $error("run lost");
  a_busy_run_excl: assert property (!(firmware_run && holdoff_busy)) else $error("both");
  a_run_after_wait: assert property ($rose(firmware_run) |-> $past(holdoff_busy))
    else $error("early run");
  // Settings
  a_trim_cap: assert property (trim_out.trim_cap_ff == trim_out.trim_capacitor * 16'h006e)
    else $error("cap");
  a_trim_load: assert property (trim_out.trim_load_ff == trim_out.trim_capacitor * 16'h0037)
    else $error("load");
  a_freq_reset: assert property ($fell(srst) |-> ref_freq_setting == 16'h6590)
    else $error("freq");
  c_run: cover property ($rose(firmware_run));
  c_abort: cover property (holdoff_busy && !clk_request);
  c_freq: cover property ($changed(ref_freq_setting));
endmodule // rcsc_chk
bind rcsc_ctrl rcsc_chk u_chk (.core_clk(core_clk), .srst(srst), .clk_request(clk_request),
  .firmware_run(firmware_run), .holdoff_busy(holdoff_busy),
  .ref_freq_setting(ref_freq_setting), .trim_out(trim_out));
`default_nettype wire

// *** tb/rcsc_osc_model.sv ***
// Slow clock sources, periods scaled down to keep the run short
`timescale 1ns/1ps
`default_nettype none
module rcsc_osc_model #(
  parameter int OSC_HALF = 500,
  parameter int EXT_HALF = 50
) (
  output var logic low_power_osc = 1'b0,
  output var logic ext_slow_clk = 1'b0
);
  // Free-running and stable from time zero
  always #(OSC_HALF) low_power_osc = ~low_power_osc;
  always #(EXT_HALF) ext_slow_clk = ~ext_slow_clk;
endmodule // rcsc_osc_model
`default_nettype wire

// *** tb/tb_rcsc_ctrl.sv ***
// Bench for the start-up control block
`timescale 1ns/1ps
`default_nettype none
module tb_rcsc_ctrl;
  import rcsc_pkg::*;
  logic core_clk = 0, srst = 1, clk_request = 0, cfg_load = 0;
  logic slow_osc, ext, firmware_run, holdoff_busy, freq_valid;
  logic [15:0] ref_freq_setting;
  rcsc_cfg_t cfg_in = '0;
  rcsc_trim_t trim_out;
  int failures = 0, cmp_count = 0;
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  rcsc_osc_model osc (.low_power_osc(slow_osc), .ext_slow_clk(ext));
  rcsc_ctrl dut (.core_clk(core_clk), .srst(srst), .clk_request(clk_request),
    .low_power_osc(slow_osc), .ext_slow_clk(ext), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .firmware_run(firmware_run), .holdoff_busy(holdoff_busy), .freq_valid(freq_valid),
    .ref_freq_setting(ref_freq_setting), .trim_out(trim_out));
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ld(input logic [4:0] w, input logic [15:0] f, input logic e);
    @(posedge core_clk);
    cfg_in <= '{w, f, 6'h3f, e};
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
  endtask
  // Hold-off length in slow ticks; request placed mid slow period for the internal oscillator only
  task automatic go(input logic [4:0] w, input logic e, input int n);
    int t = 0;
    ld(w, 16'h6590, e);
    clk_request <= 1'b0;
    repeat (2) @(posedge core_clk);
    if (!e) @(negedge slow_osc);
    @(posedge core_clk);
    clk_request <= 1'b1;
    while (firmware_run !== 1'b1 && t < 9000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    chk("holdoff", n, e ? (t + 64) / 128 : (t + 20) / 40);
  endtask
  // Drop the request mid-count, then raise it again
  task automatic abort_req();
    @(posedge core_clk);
    clk_request <= 1'b0;
    ld(5'h03, 16'h6590, 1'b0);
    clk_request <= 1'b1;
    repeat (60) @(posedge core_clk);
    #1;
    chk("busy", 1, holdoff_busy);
    go(5'h03, 1'b0, 3);
  endtask
  // Frequency word, validity and full-scale trim
  task automatic fq(input logic [15:0] f, input logic v);
    ld(5'h00, f, 1'b0);
    @(posedge core_clk);
    #1;
    chk("freq", f, ref_freq_setting);
    chk("valid", v, freq_valid);
    chk("cap", 16'h1b12, trim_out.trim_cap_ff);
    chk("load", 16'h0d89, trim_out.trim_load_ff);
    chk("trim", 6'h3f, trim_out.trim_capacitor);
  endtask
  // Values seen on the first clock after reset
  task automatic rst_dflt();
    @(posedge core_clk);
    #1;
    chk("freq rst", 16'h6590, ref_freq_setting);
    chk("valid rst", 1, freq_valid);
    chk("trim rst", RCSC_TRIM_DEFAULT, trim_out.trim_capacitor);
    chk("busy rst", 0, holdoff_busy);
    chk("run rst", 0, firmware_run);
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rst_dflt();
    go(5'h00, 1'b0, 5);
    go(5'h01, 1'b0, 1);
    go(5'h1f, 1'b0, 31);
    go(5'h02, 1'b1, 2);
    abort_req();
    fq(16'h3e80, 1'b1);
    fq(16'h4bf0, 1'b1);
    fq(16'h9600, 1'b1);
    fq(16'h3e81, 1'b0);
    conclude();
  end
endmodule // tb_rcsc_ctrl
`default_nettype wire
